// >>> core/accumulator_transfer_decode.sv
// Execute unit for the accumulator transfer instructions of a 4-bit core.
//
// How it works
// - The read-timer-control-four opcode copies timer control four into the accumulator in one cycle with carry kept.
// - The read-timer-control-five opcode loads timer control five into the accumulator in one cycle with carry kept.
// - The read-timer-control-six opcode places timer control six in the accumulator in one cycle with carry kept.
// - The read-X opcode copies pointer X into the accumulator in one cycle, with no skip and carry kept.
// - The read-Y opcode copies register Y into the accumulator in one cycle, with no skip and carry kept.
// - The read-Z opcode puts Z in accumulator bits 1..0 and zeros bits 3..2 in one cycle.
// - The write-B opcode copies the accumulator into register B in one cycle, with no skip and carry kept.
// - The write-D opcode loads register D from accumulator bits 2..0 in one cycle, with no skip and carry kept.
`timescale 1ns/100ps
`default_nettype none
module accumulator_transfer_decode #(
  parameter int DATA_W = acc_transfer_pkg::ACC_W
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 ce,
  input  wire logic                                 instr_valid,
  input  wire logic [acc_transfer_pkg::INSTR_W-1:0] instr,
  input  wire logic [DATA_W-1:0]                    timer_control_four,
  input  wire logic [DATA_W-1:0]                    timer_control_five,
  input  wire logic [DATA_W-1:0]                    timer_control_six,
  input  wire logic [DATA_W-1:0]                    pointer_x,
  input  wire logic [DATA_W-1:0]                    pointer_y,
  input  wire logic [acc_transfer_pkg::Z_W-1:0]     pointer_z,
  input  wire logic                                 acc_wr_en,
  input  wire logic [DATA_W-1:0]                    acc_wr_data,
  input  wire logic                                 carry_wr_en,
  input  wire logic                                 carry_wr_data,
  output logic      [DATA_W-1:0]                    acc,
  output logic      [DATA_W-1:0]                    reg_b,
  output logic      [acc_transfer_pkg::D_W-1:0]     reg_d,
  output logic                                      carry_flag,
  output logic                                      skip,
  output logic                                      op_hit
);
  import acc_transfer_pkg::*;

  if (DATA_W != ACC_W) begin : g_width_check
    $error("DATA_W must equal the 4-bit accumulator width");
  end

  transfer_op_t      op;
  logic              fire;
  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] acc_nxt;
  logic [DATA_W-1:0] b_r;
  logic [DATA_W-1:0] b_nxt;
  logic [D_W-1:0]    d_r;
  logic [D_W-1:0]    d_nxt;
  logic              carry_r;
  logic              carry_nxt;

  transfer_opcode_decode transfer_opcode_decode_inst (
    .instr (instr),
    .op    (op)
  );

  // An accepted instruction of this group; the core strobes one per cycle.
  assign fire   = ce && instr_valid && (op != OP_NONE);
  assign op_hit = fire;
  // No instruction of this group ever skips the next one.
  assign skip   = 1'b0;

  function automatic logic [DATA_W-1:0] zero_extend_z(
    input logic [Z_W-1:0] z
  );
    return {{(DATA_W-Z_W){1'b0}}, z};
  endfunction

  // Accumulator group. A decoded transfer wins over a write from another
  // instruction unit, since only one instruction executes per cycle and a
  // clash means the core driving both is already broken.
  always_comb begin
    acc_nxt = acc_r;
    if (ce) begin
      if (fire) begin
        case (op)
          OP_READ_TIMER_CTRL_FOUR: acc_nxt = timer_control_four;
          OP_READ_TIMER_CTRL_FIVE: acc_nxt = timer_control_five;
          OP_READ_TIMER_CTRL_SIX:  acc_nxt = timer_control_six;
          OP_READ_POINTER_X:       acc_nxt = pointer_x;
          OP_READ_POINTER_Y:       acc_nxt = pointer_y;
          OP_READ_POINTER_Z:       acc_nxt = zero_extend_z(pointer_z);
          default:                 acc_nxt = acc_r;
        endcase
      end else if (acc_wr_en) begin
        acc_nxt = acc_wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= ACC_RESET;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Registers B and D take the accumulator as it stands before the edge.
  always_comb begin
    b_nxt = b_r;
    d_nxt = d_r;
    if (fire && op == OP_WRITE_B_FROM_ACC) begin
      b_nxt = acc_r;
    end
    if (fire && op == OP_WRITE_D_FROM_ACC) begin
      d_nxt = acc_r[D_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      b_r <= B_RESET;
      d_r <= D_RESET;
    end else begin
      b_r <= b_nxt;
      d_r <= d_nxt;
    end
  end

  // Carry is owned by other instructions; this group never writes it, and a transfer blocks their carry write in the same cycle.
  always_comb begin
    carry_nxt = carry_r;
    if (ce && carry_wr_en && !fire) begin
      carry_nxt = carry_wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      carry_r <= CARRY_RESET;
    end else begin
      carry_r <= carry_nxt;
    end
  end

  assign acc        = acc_r;
  assign reg_b      = b_r;
  assign reg_d      = d_r;
  assign carry_flag = carry_r;

  property acc_loads_p(logic [8:0] code, logic [DATA_W-1:0] src);
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == code) |=> (acc_r == $past(src)) && $stable(carry_r);
  endproperty

  timer_four_read_a: assert property (
    acc_loads_p(OP_READ_TIMER_CTRL_FOUR, timer_control_four))
    else $error("timer control four not copied to accumulator");

  timer_five_read_a: assert property (
    acc_loads_p(OP_READ_TIMER_CTRL_FIVE, timer_control_five))
    else $error("timer control five not copied to accumulator");

  timer_six_read_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == OP_READ_TIMER_CTRL_SIX) |->
      ##1 (acc_r == $past(timer_control_six)) && !$changed(carry_r))
    else $error("timer control six not copied to accumulator");

  pointer_x_read_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == OP_READ_POINTER_X) |-> !skip ##1
      (acc_r == $past(pointer_x)) && (carry_r == $past(carry_r)))
    else $error("pointer X not copied to accumulator");

  pointer_y_read_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == OP_READ_POINTER_Y) |-> !skip ##1
      (acc_r == $past(pointer_y)) && $stable(carry_r))
    else $error("register Y not copied to accumulator");

  pointer_z_read_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == OP_READ_POINTER_Z) |=>
      (acc_r[DATA_W-1:Z_W] == '0) && (acc_r[Z_W-1:0] == $past(pointer_z)))
    else $error("register Z not zero extended into accumulator");

  b_write_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == OP_WRITE_B_FROM_ACC) |=>
      (b_r == $past(acc_r)) && $stable(acc_r) && $stable(carry_r))
    else $error("register B not loaded from accumulator");

  d_write_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == OP_WRITE_D_FROM_ACC) |=>
      (d_r == $past(acc_r[D_W-1:0])) && $stable(carry_r) && $stable(b_r))
    else $error("register D not loaded from accumulator");

  freeze_hold_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !ce |=> $stable(acc_r) && $stable(b_r) && $stable(d_r) && $stable(carry_r))
    else $error("state changed while clock enable was low");

  // A word outside the group must leave the accumulator, B and D of this unit alone,
  // so a decode alias would show up here rather than as a silent corruption.
  unknown_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (ce && instr_valid && !fire && !acc_wr_en) |=>
      $stable(acc_r) && $stable(b_r) && $stable(d_r))
    else $error("word outside the group changed a register");

  acc_side_write_a: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (ce && acc_wr_en && !fire) |=> (acc_r == $past(acc_wr_data)))
    else $error("side write to accumulator lost with no transfer");

  carry_clash_c: cover property (
    @(posedge ref_clk) disable iff (!reset_n)
    fire && carry_wr_en);

  timer_then_b_c: cover property (
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == OP_READ_TIMER_CTRL_FOUR) ##1
    (fire && op == OP_WRITE_B_FROM_ACC));

  z_then_d_c: cover property (
    @(posedge ref_clk) disable iff (!reset_n)
    (fire && op == OP_READ_POINTER_Z) ##1
    (fire && op == OP_WRITE_D_FROM_ACC));

  stall_mid_c: cover property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!ce && instr_valid && op != OP_NONE) ##1 fire);

endmodule
`default_nettype wire

// >>> core/transfer_opcode_decode.sv
// Combinational decoder from an instruction word to a transfer operation.
`timescale 1ns/100ps
`default_nettype none
module transfer_opcode_decode (
  input  wire logic [acc_transfer_pkg::INSTR_W-1:0] instr,
  output var acc_transfer_pkg::transfer_op_t        op
);
  import acc_transfer_pkg::*;

  always_comb begin
    case (instr)
      OPC_READ_TIMER_CTRL_FOUR: op = OP_READ_TIMER_CTRL_FOUR;
      OPC_READ_TIMER_CTRL_FIVE: op = OP_READ_TIMER_CTRL_FIVE;
      OPC_READ_TIMER_CTRL_SIX:  op = OP_READ_TIMER_CTRL_SIX;
      OPC_READ_POINTER_X:       op = OP_READ_POINTER_X;
      OPC_READ_POINTER_Y:       op = OP_READ_POINTER_Y;
      OPC_READ_POINTER_Z:       op = OP_READ_POINTER_Z;
      OPC_WRITE_B_FROM_ACC:     op = OP_WRITE_B_FROM_ACC;
      OPC_WRITE_D_FROM_ACC:     op = OP_WRITE_D_FROM_ACC;
      default:                  op = OP_NONE;
    endcase
  end

endmodule
`default_nettype wire

// >>> include/acc_transfer_pkg.sv
// Shared opcodes, widths and reset values for the accumulator transfer logic.
package acc_transfer_pkg;

  localparam int INSTR_W = 10;
  localparam int ACC_W   = 4;
  localparam int Z_W     = 2;
  localparam int D_W     = 3;

  // One-word opcodes of the transfer group.
  localparam logic [INSTR_W-1:0] OPC_READ_TIMER_CTRL_FOUR = 10'h24e;
  localparam logic [INSTR_W-1:0] OPC_READ_TIMER_CTRL_FIVE = 10'h24f;
  localparam logic [INSTR_W-1:0] OPC_READ_TIMER_CTRL_SIX  = 10'h250;
  localparam logic [INSTR_W-1:0] OPC_READ_POINTER_X       = 10'h052;
  localparam logic [INSTR_W-1:0] OPC_READ_POINTER_Y       = 10'h01f;
  localparam logic [INSTR_W-1:0] OPC_READ_POINTER_Z       = 10'h053;
  localparam logic [INSTR_W-1:0] OPC_WRITE_B_FROM_ACC     = 10'h00e;
  localparam logic [INSTR_W-1:0] OPC_WRITE_D_FROM_ACC     = 10'h029;

  localparam logic [ACC_W-1:0] ACC_RESET   = 4'h0;
  localparam logic [ACC_W-1:0] B_RESET     = 4'h0;
  localparam logic [D_W-1:0]   D_RESET     = 3'h0;
  localparam logic             CARRY_RESET = 1'b0;

  // Cycles from an accepted instruction to its visible result.
  localparam int EXEC_CYCLES = 1;

  typedef enum logic [8:0] {
    OP_NONE                 = 9'h001,
    OP_READ_TIMER_CTRL_FOUR = 9'h002,
    OP_READ_TIMER_CTRL_FIVE = 9'h004,
    OP_READ_TIMER_CTRL_SIX  = 9'h008,
    OP_READ_POINTER_X       = 9'h010,
    OP_READ_POINTER_Y       = 9'h020,
    OP_READ_POINTER_Z       = 9'h040,
    OP_WRITE_B_FROM_ACC     = 9'h080,
    OP_WRITE_D_FROM_ACC     = 9'h100
  } transfer_op_t;

endpackage

// >>> tb/accumulator_transfer_decode_tb.sv
// Self-checking testbench for the accumulator transfer execute unit.
`timescale 1ns/100ps
`default_nettype none
module accumulator_transfer_decode_tb;
  import acc_transfer_pkg::*;

  typedef struct {
    logic [INSTR_W-1:0] op;
    logic [3:0]         acc;
    logic [3:0]         b;
    logic [2:0]         d;
    logic               hit;
    logic               carry;
  } row_t;

  logic               ref_clk = 1'b0;
  logic               reset_n, ce, instr_valid;
  logic [INSTR_W-1:0] instr;
  logic [3:0]         tc4, tc5, tc6, px, py, acc_wd, acc, reg_b;
  logic [1:0]         pz;
  logic [2:0]         reg_d;
  logic               acc_we, carry_we, carry_wd, carry_flag, skip, op_hit;
  int                 miscompares  = 0;
  int                 total_checks = 0;

  // Back-to-back chain: each row sees the state left by the row above.
  row_t rows [14] = '{
    '{OPC_READ_TIMER_CTRL_FOUR, 4'h9, 4'h0, 3'h0, 1'b1, 1'b1},
    '{OPC_WRITE_B_FROM_ACC,     4'h9, 4'h9, 3'h0, 1'b1, 1'b1},
    '{OPC_WRITE_D_FROM_ACC,     4'h9, 4'h9, 3'h1, 1'b1, 1'b1},
    '{OPC_READ_TIMER_CTRL_FIVE, 4'h6, 4'h9, 3'h1, 1'b1, 1'b1},
    '{OPC_WRITE_D_FROM_ACC,     4'h6, 4'h9, 3'h6, 1'b1, 1'b1},
    '{OPC_READ_TIMER_CTRL_SIX,  4'hc, 4'h9, 3'h6, 1'b1, 1'b1},
    '{OPC_WRITE_B_FROM_ACC,     4'hc, 4'hc, 3'h6, 1'b1, 1'b1},
    '{OPC_WRITE_D_FROM_ACC,     4'hc, 4'hc, 3'h4, 1'b1, 1'b1},
    '{OPC_READ_POINTER_X,       4'h5, 4'hc, 3'h4, 1'b1, 1'b1},
    '{OPC_READ_POINTER_Y,       4'ha, 4'hc, 3'h4, 1'b1, 1'b1},
    '{OPC_WRITE_B_FROM_ACC,     4'ha, 4'ha, 3'h4, 1'b1, 1'b1},
    '{OPC_READ_POINTER_Z,       4'h3, 4'ha, 3'h4, 1'b1, 1'b1},
    '{OPC_WRITE_D_FROM_ACC,     4'h3, 4'ha, 3'h3, 1'b1, 1'b1},
    '{10'h3ff,                  4'h3, 4'ha, 3'h3, 1'b0, 1'b0}
  };

  always #5 ref_clk = ~ref_clk;

  accumulator_transfer_decode accumulator_transfer_decode_inst (
    .ref_clk            (ref_clk),
    .reset_n            (reset_n),
    .ce                 (ce),
    .instr_valid        (instr_valid),
    .instr              (instr),
    .timer_control_four (tc4),
    .timer_control_five (tc5),
    .timer_control_six  (tc6),
    .pointer_x          (px),
    .pointer_y          (py),
    .pointer_z          (pz),
    .acc_wr_en          (acc_we),
    .acc_wr_data        (acc_wd),
    .carry_wr_en        (carry_we),
    .carry_wr_data      (carry_wd),
    .acc                (acc),
    .reg_b              (reg_b),
    .reg_d              (reg_d),
    .carry_flag         (carry_flag),
    .skip               (skip),
    .op_hit             (op_hit)
  );

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs move 1 ns after the edge so the design never races the bench.
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk_state(input logic [3:0] a, input logic [3:0] b,
                           input logic [2:0] d, input logic c);
    chk(acc, a);
    chk(reg_b, b);
    chk(reg_d, d);
    chk(carry_flag, c);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    reset_n     = 1'b0;
    ce          = 1'b1;
    instr_valid = 1'b0;
    instr       = '0;
    tc4         = 4'h9;
    tc5         = 4'h6;
    tc6         = 4'hc;
    px          = 4'h5;
    py          = 4'ha;
    pz          = 2'h3;
    acc_we      = 1'b0;
    acc_wd      = 4'hf;
    carry_we    = 1'b0;
    carry_wd    = 1'b1;
    repeat (6) step();
    reset_n = 1'b1;
    chk_state(4'h0, 4'h0, 3'h0, 1'b0);
    $display("test reset done");
    carry_we = 1'b1;
    step();
    chk(carry_flag, 1'b1);
    // A carry write of 0 stays on through the table: every transfer keeps
    // the carry at 1, and only the word outside the group lets it through.
    carry_wd    = 1'b0;
    instr_valid = 1'b1;
    foreach (rows[i]) begin
      instr = rows[i].op;
      #1 chk(op_hit, rows[i].hit);
      chk(skip, 1'b0);
      step();
      chk(acc, rows[i].acc);
      chk(reg_b, rows[i].b);
      chk(reg_d, rows[i].d);
      chk(carry_flag, rows[i].carry);
    end
    $display("test table done");
    carry_we = 1'b0;
    ce       = 1'b0;
    instr    = OPC_READ_TIMER_CTRL_FOUR;
    #1 chk(op_hit, 1'b0);
    step();
    chk(acc, 4'h3);
    ce     = 1'b1;
    acc_we = 1'b1;
    instr  = OPC_READ_POINTER_X;
    step();
    chk(acc, 4'h5);
    // With no transfer, side writes of accumulator and carry both land.
    instr_valid = 1'b0;
    carry_we    = 1'b1;
    carry_wd    = 1'b1;
    step();
    chk(acc, 4'hf);
    chk(carry_flag, 1'b1);
    acc_we      = 1'b0;
    carry_wd    = 1'b0;
    instr_valid = 1'b1;
    pz          = 2'h2;
    instr       = OPC_READ_POINTER_Z;
    step();
    chk(acc, 4'h2);
    instr = OPC_WRITE_D_FROM_ACC;
    step();
    chk(reg_d, 3'h2);
    chk(carry_flag, 1'b1);
    $display("test awkward cases done");
    instr_valid = 1'b0;
    carry_we    = 1'b0;
    reset_n     = 1'b0;
    #1 chk_state(4'h0, 4'h0, 3'h0, 1'b0);
    step();
    reset_n = 1'b1;
    step();
    chk_state(4'h0, 4'h0, 3'h0, 1'b0);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
